// ---- adc_ctrl_consts.svh ----
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define OFF_CTRL        8'h00
`define OFF_CHAN        8'h04
`define OFF_RESH        8'h08
`define OFF_RESL        8'h0c
`define OFF_WINLO       8'h10
`define OFF_WINHI       8'h14
`define OFF_STATUS      8'h18
`define OFF_MASK        8'h1c

// ==========================================================================
// Field positions
`define CTRL_EN         0
`define CTRL_TSEL_LO    1
`define CTRL_TSEL_HI    2
`define CTRL_SWSTART    3
`define CTRL_LJUST      4
`define CTRL_RES10      5
`define CHAN_SEL_LO     0
`define CHAN_SEL_HI     3
`define CHAN_DIFF_LO    4
`define CHAN_DIFF_HI    7
`define CHAN_GAIN_LO    8
`define CHAN_GAIN_HI    10
`define STAT_DONE       0
`define STAT_WIN        1
`define STAT_BUSY       2

// ==========================================================================
// Reset values and codes
`define CHAN_SEL_RST    4'h0
`define CHAN_DIFF_RST   4'h0
`define GAIN_RST        3'h1
`define WINLO_RST       16'hffff
`define WINHI_RST       16'h0000
`define CHAN_TEMP       4'h8
`define GAIN_MAX        3'h5

// ==========================================================================
// Timing
`define CLK_PERIOD_NS   4
`define TRACK_NS        1500
`define TRACK_CYC       ((`TRACK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ---- adc_ctrl_pkg.sv ----
package adc_ctrl_pkg;

    // Gray coded along idle -> track -> convert -> done
    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_TRACK = 2'b01,
        SEQ_CONV  = 2'b11,
        SEQ_DONE  = 2'b10
    } seq_state_t;

    typedef enum logic [1:0] {
        TRIG_SW     = 2'b00,
        TRIG_TIMER2 = 2'b01,
        TRIG_TIMER3 = 2'b10,
        TRIG_EXT    = 2'b11
    } trig_sel_t;

endpackage : adc_ctrl_pkg

// ---- conv_seq.sv ----
`include "adc_ctrl_consts.svh"

module conv_seq (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control
    input  wire logic enable,
    input  wire logic trig,
    // Converter handshake
    input  wire logic conv_done,
    output logic      start,
    output logic      busy,
    output logic      done
);
    import adc_ctrl_pkg::*;

    localparam logic [8:0] TRACK_LAST = 9'(`TRACK_CYC - 1);

    seq_state_t state_reg;
    seq_state_t state_next;
    logic [8:0] cnt_reg;
    logic [8:0] cnt_next;
    logic       start_reg;
    logic       start_next;

    // ======================================================================
    // Sequencer
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        start_next = start_reg;
        case (state_reg)
            SEQ_IDLE: begin
                // Triggers while busy never reach here R11
                if (enable && trig) begin
                    state_next = SEQ_TRACK;
                    cnt_next   = 9'h000;
                    start_next = 1'b1;
                end
            end
            SEQ_TRACK: begin
                if (cnt_reg == TRACK_LAST) begin
                    state_next = SEQ_CONV;
                    start_next = 1'b0;
                end else begin
                    cnt_next = cnt_reg + 9'h001;
                end
            end
            SEQ_CONV: begin
                if (conv_done) begin
                    state_next = SEQ_DONE;
                end
            end
            SEQ_DONE: begin
                // Back to idle at once so back-to-back triggers keep full rate R10
                state_next = SEQ_IDLE;
            end
            default: begin
                state_next = SEQ_IDLE;
                start_next = 1'b0;
            end
        endcase
        // Shutdown aborts any conversion in flight R9
        if (!enable) begin
            state_next = SEQ_IDLE;
            start_next = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= SEQ_IDLE;
            cnt_reg   <= 9'h000;
            start_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            start_reg <= start_next;
        end
    end

    assign start = start_reg;
    assign busy  = (state_reg != SEQ_IDLE);
    assign done  = (state_reg == SEQ_CONV) && conv_done && enable;

endmodule : conv_seq

// ---- adc_ctrl.sv ----
// Overview of operation
// R1: Conversion starts from software, timer 2 overflow, timer 3 overflow or external pin.
// R2: End of conversion sets a pollable done flag and raises an interrupt.
// R3: Each finished result, 12 or 10 bits, is latched into two byte registers.
// R4: Software chooses right or left justification of the latched result.
// R5: Window flag and interrupt only when the result lies within the bounds.
// R6: Nine-way channel selector; code eight is the temperature sensor.
// R7: Each external input pair is two single-ended or one differential channel.
// R8: Amplifier gain selectable as 0.5, 1, 2, 4, 8 or 16.
// R9: Software can shut the converter down, stopping all conversions.
// R10: Sequencer sustains back-to-back conversions up to 100 ksps.
// R11: Triggers during a conversion, or from unselected sources, are ignored.
`include "adc_ctrl_consts.svh"

module adc_ctrl (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Start sources
    input  wire logic        timer2_ovf,
    input  wire logic        timer3_ovf,
    input  wire logic        ext_start,
    // Analog converter
    input  wire logic [11:0] adc_data,
    input  wire logic        adc_done,
    output logic             adc_start,
    output logic      [3:0]  adc_chan,
    output logic             adc_diff,
    output logic      [2:0]  adc_gain,
    output logic             adc_pwr_dn,
    // Interrupt
    output logic             irq
);
    import adc_ctrl_pkg::*;

    // ======================================================================
    // Functions
    function automatic logic [15:0] justify(input logic [11:0] raw,
                                            input logic        res10,
                                            input logic        left);
        logic [15:0] word;
        if (res10) begin
            word = left ? {raw[9:0], 6'h00} : {6'h00, raw[9:0]};
        end else begin
            word = left ? {raw, 4'h0} : {4'h0, raw};
        end
        return word;
    endfunction : justify

    // ======================================================================
    // Declarations
    logic        en_reg,     en_next;
    trig_sel_t   tsel_reg,   tsel_next;
    logic        ljust_reg,  ljust_next;
    logic        res10_reg,  res10_next;
    logic        sw_go_reg,  sw_go_next;
    logic [3:0]  sel_reg,    sel_next;
    logic [3:0]  diff_reg,   diff_next;
    logic [2:0]  gain_reg,   gain_next;
    logic [7:0]  resh_reg,   resh_next;
    logic [7:0]  resl_reg,   resl_next;
    logic [15:0] winlo_reg,  winlo_next;
    logic [15:0] winhi_reg,  winhi_next;
    logic [1:0]  stat_reg,   stat_next;
    logic [1:0]  mask_reg,   mask_next;
    logic        irq_reg,    irq_next;
    logic        ext_prev_reg, ext_prev_next;
    logic [31:0] prdata_reg, prdata_next;
    logic        pready_reg, pready_next;
    logic        pslverr_reg, pslverr_next;
    logic [3:0]  chan_reg,   chan_next;
    logic        cdiff_reg,  cdiff_next;
    logic [2:0]  cgain_reg,  cgain_next;
    logic        pdn_reg,    pdn_next;

    logic        setup;
    logic        wr_acc;
    logic        mapped;
    logic [31:0] rd_mux;
    logic        trig;
    logic        busy;
    logic        conv_fin;
    logic [15:0] result;
    logic        in_win;

    assign setup  = psel && !penable;
    assign wr_acc = psel && penable && pready_reg && pwrite;

    // ======================================================================
    // Trigger selection
    always_comb begin
        ext_prev_next = ext_start;
        case (tsel_reg)
            TRIG_SW:     trig = sw_go_reg;
            TRIG_TIMER2: trig = timer2_ovf;
            TRIG_TIMER3: trig = timer3_ovf;
            TRIG_EXT:    trig = ext_start && !ext_prev_reg;
            default:     trig = 1'b0;
        endcase
        // Only the selected source counts, and only when idle R1 R11
        trig = trig && en_reg && !busy;
    end

    conv_seq conv_seq_inst (
        .pclk      (pclk),
        .presetn   (presetn),
        .enable    (en_reg),
        .trig      (trig),
        .conv_done (adc_done),
        .start     (adc_start),
        .busy      (busy),
        .done      (conv_fin)
    );

    // ======================================================================
    // Result and window
    always_comb begin
        result = justify(adc_data, res10_reg, ljust_reg); // R3 R4
        in_win = (result >= winlo_reg) && (result <= winhi_reg); // R5
    end

    // ======================================================================
    // Read decode
    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            `OFF_CTRL: begin
                rd_mux[`CTRL_EN]                       = en_reg;
                rd_mux[`CTRL_TSEL_HI:`CTRL_TSEL_LO]    = tsel_reg;
                rd_mux[`CTRL_LJUST]                    = ljust_reg;
                rd_mux[`CTRL_RES10]                    = res10_reg;
            end
            `OFF_CHAN: begin
                rd_mux[`CHAN_SEL_HI:`CHAN_SEL_LO]      = sel_reg;
                rd_mux[`CHAN_DIFF_HI:`CHAN_DIFF_LO]    = diff_reg;
                rd_mux[`CHAN_GAIN_HI:`CHAN_GAIN_LO]    = gain_reg;
            end
            `OFF_RESH:   rd_mux[7:0]  = resh_reg;
            `OFF_RESL:   rd_mux[7:0]  = resl_reg;
            `OFF_WINLO:  rd_mux[15:0] = winlo_reg;
            `OFF_WINHI:  rd_mux[15:0] = winhi_reg;
            `OFF_STATUS: begin
                rd_mux[`STAT_WIN:`STAT_DONE] = stat_reg; // R2
                rd_mux[`STAT_BUSY]           = busy;
            end
            `OFF_MASK:   rd_mux[1:0]  = mask_reg;
            default:     mapped       = 1'b0;
        endcase
    end

    // ======================================================================
    // Bus answer: zero wait states, data set up during the setup cycle
    always_comb begin
        pready_next  = setup;
        pslverr_next = setup && !mapped;
        prdata_next  = setup ? rd_mux : prdata_reg;
    end

    // ======================================================================
    // Configuration registers
    always_comb begin
        en_next    = en_reg;
        tsel_next  = tsel_reg;
        ljust_next = ljust_reg;
        res10_next = res10_reg;
        sw_go_next = 1'b0;
        sel_next   = sel_reg;
        diff_next  = diff_reg;
        gain_next  = gain_reg;
        winlo_next = winlo_reg;
        winhi_next = winhi_reg;
        mask_next  = mask_reg;
        if (wr_acc) begin
            case (paddr)
                `OFF_CTRL: begin
                    en_next    = pwdata[`CTRL_EN]; // R9
                    tsel_next  = trig_sel_t'(pwdata[`CTRL_TSEL_HI:`CTRL_TSEL_LO]);
                    ljust_next = pwdata[`CTRL_LJUST]; // R4
                    res10_next = pwdata[`CTRL_RES10];
                    sw_go_next = pwdata[`CTRL_SWSTART]; // R1
                end
                `OFF_CHAN: begin
                    // Codes past the sensor fold onto it R6
                    sel_next = (pwdata[`CHAN_SEL_HI:`CHAN_SEL_LO] > `CHAN_TEMP) ?
                               `CHAN_TEMP : pwdata[`CHAN_SEL_HI:`CHAN_SEL_LO];
                    diff_next = pwdata[`CHAN_DIFF_HI:`CHAN_DIFF_LO]; // R7
                    // Unused gain codes clamp to the highest gain R8
                    gain_next = (pwdata[`CHAN_GAIN_HI:`CHAN_GAIN_LO] > `GAIN_MAX) ?
                                `GAIN_MAX : pwdata[`CHAN_GAIN_HI:`CHAN_GAIN_LO];
                end
                `OFF_WINLO: winlo_next = pwdata[15:0];
                `OFF_WINHI: winhi_next = pwdata[15:0];
                `OFF_MASK:  mask_next  = pwdata[1:0];
                default: ;
            endcase
        end
    end

    // ======================================================================
    // Results, status and interrupt
    always_comb begin
        resh_next = resh_reg;
        resl_next = resl_reg;
        stat_next = stat_reg;
        // Write one to clear; a same-cycle event still sets
        if (wr_acc && paddr == `OFF_STATUS) begin
            stat_next = stat_reg & ~pwdata[`STAT_WIN:`STAT_DONE];
        end
        if (conv_fin) begin
            resh_next = result[15:8]; // R3
            resl_next = result[7:0]; // R3
            stat_next[`STAT_DONE] = 1'b1; // R2
            if (in_win) begin
                stat_next[`STAT_WIN] = 1'b1; // R5
            end
        end
        irq_next = |(stat_next & mask_next); // R2 R5
    end

    // ======================================================================
    // Analog control outputs
    always_comb begin
        pdn_next   = !en_next; // R9
        cgain_next = gain_next; // R8
        cdiff_next = 1'b0;
        chan_next  = sel_next;
        // Differential pair uses the even input as plus side R7
        if (sel_next != `CHAN_TEMP && diff_next[sel_next[2:1]]) begin
            cdiff_next = 1'b1;
            chan_next  = {sel_next[3:1], 1'b0};
        end
    end

    // ======================================================================
    // State registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg       <= 1'b0;
            tsel_reg     <= TRIG_SW;
            ljust_reg    <= 1'b0;
            res10_reg    <= 1'b0;
            sw_go_reg    <= 1'b0;
            sel_reg      <= `CHAN_SEL_RST;
            diff_reg     <= `CHAN_DIFF_RST;
            gain_reg     <= `GAIN_RST;
            resh_reg     <= 8'h00;
            resl_reg     <= 8'h00;
            winlo_reg    <= `WINLO_RST;
            winhi_reg    <= `WINHI_RST;
            stat_reg     <= 2'h0;
            mask_reg     <= 2'h0;
            irq_reg      <= 1'b0;
            ext_prev_reg <= 1'b0;
            prdata_reg   <= 32'h0000_0000;
            pready_reg   <= 1'b0;
            pslverr_reg  <= 1'b0;
            chan_reg     <= `CHAN_SEL_RST;
            cdiff_reg    <= 1'b0;
            cgain_reg    <= `GAIN_RST;
            pdn_reg      <= 1'b1;
        end else begin
            en_reg       <= en_next;
            tsel_reg     <= tsel_next;
            ljust_reg    <= ljust_next;
            res10_reg    <= res10_next;
            sw_go_reg    <= sw_go_next;
            sel_reg      <= sel_next;
            diff_reg     <= diff_next;
            gain_reg     <= gain_next;
            resh_reg     <= resh_next;
            resl_reg     <= resl_next;
            winlo_reg    <= winlo_next;
            winhi_reg    <= winhi_next;
            stat_reg     <= stat_next;
            mask_reg     <= mask_next;
            irq_reg      <= irq_next;
            ext_prev_reg <= ext_prev_next;
            prdata_reg   <= prdata_next;
            pready_reg   <= pready_next;
            pslverr_reg  <= pslverr_next;
            chan_reg     <= chan_next;
            cdiff_reg    <= cdiff_next;
            cgain_reg    <= cgain_next;
            pdn_reg      <= pdn_next;
        end
    end

    // ======================================================================
    // Outputs
    assign prdata     = prdata_reg;
    assign pready     = pready_reg;
    assign pslverr    = pslverr_reg;
    assign adc_chan   = chan_reg;
    assign adc_diff   = cdiff_reg;
    assign adc_gain   = cgain_reg;
    assign adc_pwr_dn = pdn_reg;
    assign irq        = irq_reg;

endmodule : adc_ctrl

// ---- adc_ctrl_properties.sv ----
`include "adc_ctrl_consts.svh"

module adc_ctrl_properties (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB slave
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Analog converter
    input wire logic        adc_done,
    input wire logic        adc_start,
    input wire logic [3:0]  adc_chan,
    input wire logic        adc_diff,
    input wire logic [2:0]  adc_gain,
    input wire logic        adc_pwr_dn
);
    // =========================================================
    // Helper state
    logic [9:0] track_reg;
    logic [9:0] track_next;
    logic       wait_reg;
    logic       wait_next;
    logic       acc;
    logic       unmapped;

    assign acc      = psel && penable && pready;
    assign unmapped = (paddr > `OFF_MASK) || (paddr[1:0] != 2'b00);

    // Wait flag: start fall to converter done; shutdown clears
    always_comb begin
        track_next = adc_start ? track_reg + 10'h001 : 10'h000;
        wait_next  = !adc_done && !adc_pwr_dn && (wait_reg || (!adc_start && track_reg != 10'h000));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            track_reg <= 10'h000;
            wait_reg  <= 1'b0;
        end else begin
            track_reg <= track_next;
            wait_reg  <= wait_next;
        end
    end

    // =========================================================
    // Properties
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    pready_answer_a: assert property (psel && !penable |=> pready) else $error("pready late");
    pready_pulse_a: assert property (pready |-> psel && penable ##1 !pready) else $error("pready not one cycle");
    slverr_map_a: assert property (acc |-> pslverr == unmapped) else $error("pslverr wrong");
    unmapped_zero_a: assert property (acc && !pwrite && unmapped |-> prdata == 32'h0) else $error("unmapped data");
    swstart_read_a: assert property (acc && !pwrite && paddr == `OFF_CTRL |-> !prdata[`CTRL_SWSTART])
        else $error("sw start reads one");
    track_len_a: assert property (!adc_start && track_reg != 10'h000 && !adc_pwr_dn |-> track_reg == `TRACK_CYC)
        else $error("track length wrong");
    conv_hold_a: assert property (wait_reg |-> !adc_start) else $error("restart while busy");
    done_gap_a: assert property (adc_done && wait_reg |=> !adc_start [*2]) else $error("restart too early");
    sel_clamp_a: assert property (adc_chan <= `CHAN_TEMP && adc_gain <= `GAIN_MAX) else $error("select range");
    diff_pair_a: assert property (adc_diff |-> !adc_chan[0] && adc_chan != `CHAN_TEMP) else $error("diff pair");
    pd_stop_a: assert property ($rose(adc_pwr_dn) |-> ##[0:1] !adc_start) else $error("start in shutdown");
endmodule : adc_ctrl_properties

bind adc_ctrl adc_ctrl_properties adc_ctrl_properties_inst (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_done(adc_done), .adc_start(adc_start),
    .adc_chan(adc_chan), .adc_diff(adc_diff), .adc_gain(adc_gain), .adc_pwr_dn(adc_pwr_dn));

// ---- adc_conv_model.sv ----
module adc_conv_model (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Converter pins
    input wire logic        adc_start,
    output logic            adc_done,
    output logic     [11:0] adc_data,
    // Test control
    input wire logic [11:0] next_value,
    input wire logic [7:0]  conv_cycles,
    output int              n_conv
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       prev_start;
    int         cnt;
    logic [11:0] last;

    // Data outside the done cycle is the inverse, so a stale capture shows
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_start <= 1'b0;
            cnt        <= 0;
            adc_done   <= 1'b0;
            adc_data   <= 12'hfff;
            last       <= 12'h000;
            n_conv     <= 0;
        end else begin
            prev_start <= adc_start;
            adc_done   <= 1'b0;
            adc_data   <= ~last;
            if (prev_start && !adc_start) begin
                cnt <= int'(conv_cycles);
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end else if (cnt == 1) begin
                cnt      <= 0;
                adc_done <= 1'b1;
                adc_data <= next_value;
                last     <= next_value;
                n_conv   <= n_conv + 1;
            end
        end
    end
endmodule : adc_conv_model

// ---- tb_adc_ctrl.sv ----
`include "adc_ctrl_consts.svh"

module tb_adc_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import adc_ctrl_pkg::*;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        timer2_ovf, timer3_ovf, ext_start, adc_done, adc_start, adc_diff, adc_pwr_dn, irq;
    logic [7:0]  paddr, conv_cycles;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [11:0] adc_data, next_value;
    logic [3:0]  adc_chan;
    logic [2:0]  adc_gain;
    int          n_conv, n_errors, check_count;
    logic [15:0] exp_q[$];
    localparam logic [31:0] rst_tab [9] = '{32'h0, 32'h100, 32'h0, 32'h0, 32'hffff, 32'h0, 32'h0, 32'h0, 32'h0};

    adc_ctrl adc_ctrl_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer2_ovf(timer2_ovf), .timer3_ovf(timer3_ovf), .ext_start(ext_start), .adc_data(adc_data),
        .adc_done(adc_done), .adc_start(adc_start), .adc_chan(adc_chan), .adc_diff(adc_diff),
        .adc_gain(adc_gain), .adc_pwr_dn(adc_pwr_dn), .irq(irq));
    adc_conv_model adc_conv_model_inst (.pclk(pclk), .presetn(presetn), .adc_start(adc_start),
        .adc_done(adc_done), .adc_data(adc_data), .next_value(next_value), .conv_cycles(conv_cycles),
        .n_conv(n_conv));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // =========================================================
    // Tasks
    task automatic finish_test();
        $display("Checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(negedge pclk);
            if (pready === 1'b1) break;
            @(posedge pclk);
        end
        if (k == 20) begin
            n_errors++;
            finish_test();
        end
        rd  = prdata;
        err = pslverr;
        @(posedge pclk);
        {psel, penable} <= 2'b00;
    endtask : apb

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, rd, exp);
    endtask : rd_chk

    // Bounded wait: 0 start, 1 done, 2 irq
    task automatic wait_sig(input int k, input logic lvl);
        int n;
        for (n = 0; n < 3000; n++) begin
            @(negedge pclk);
            if (((k == 0) ? adc_start : (k == 1) ? adc_done : irq) === lvl) break;
        end
        if (n == 3000) begin
            n_errors++;
            finish_test();
        end
    endtask : wait_sig

    task automatic fire(input int src, input logic [31:0] ctrl);
        if (src == 0) begin
            apb(1'b1, `OFF_CTRL, ctrl | 32'h8);
        end else begin
            @(posedge pclk);
            {timer2_ovf, timer3_ovf, ext_start} <= {src == 1, src == 2, src == 3};
            @(posedge pclk);
            {timer2_ovf, timer3_ovf, ext_start} <= 3'h0;
        end
    endtask : fire

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [15:0] justify(input logic [11:0] d, input logic lj, input logic r10);
        logic [15:0] w;
        w = r10 ? {6'h0, d[9:0]} : {4'h0, d};
        if (lj) w = r10 ? w << 6 : w << 4;
        return w;
    endfunction : justify

    // =========================================================
    // Main sequence
    initial begin
        logic [31:0] ctrl;
        logic [15:0] word, lo, hi;
        int          i, s, t;
        {presetn, psel, penable, pwrite, timer2_ovf, timer3_ovf, ext_start} = 7'h00;
        {paddr, pwdata, next_value, conv_cycles} = '0;
        {n_errors, check_count} = '0;
        seed = 32'd81458;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 9; i++) begin
            rd_chk("reset", 8'(i * 4), rst_tab[i]);
            chk("pslverr", 32'(err), 32'(i == 8));
        end
        chk("pwr_dn", 32'(adc_pwr_dn), 32'h1);
        fire(0, 32'h0);
        repeat (4) @(negedge pclk);
        chk("start_off", 32'(adc_start), 32'h0);
        apb(1'b1, `OFF_CHAN, 32'h7ff);
        rd_chk("chan", `OFF_CHAN, 32'h5f8);
        chk("temp", 32'({adc_chan, adc_diff}), 32'h10);
        for (s = 0; s < 6; s++) begin
            apb(1'b1, `OFF_CHAN, 32'(s << 8) | (s[0] ? 32'h23 : 32'h03));
            @(negedge pclk);
            chk("gain", 32'(adc_gain), 32'(s));
            chk("pair", 32'({adc_chan, adc_diff}), s[0] ? 32'h5 : 32'h6);
        end
        // Each trigger source, window in and out
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            next_value  = seed[11:0];
            conv_cycles = 8'(seed[17:12]) + 8'h01;
            word = justify(next_value, i[0], i[1]);
            lo = i[0] ? word ^ 16'h1 : 16'h0;
            hi = i[0] ? word ^ 16'h1 : 16'hffff;
            apb(1'b1, `OFF_WINLO, 32'(lo));
            apb(1'b1, `OFF_WINHI, 32'(hi));
            apb(1'b1, `OFF_MASK, (i == 1) ? 32'h2 : 32'h3);
            ctrl = 32'h1 | 32'(i << 1) | 32'(i << 4);
            apb(1'b1, `OFF_CTRL, ctrl);
            @(negedge pclk);
            chk("pwr_up", 32'(adc_pwr_dn), 32'h0);
            for (s = 0; s < 4; s++) if (s != i) fire(s, ctrl);
            repeat (3) @(negedge pclk);
            chk("unselected", 32'(adc_start), 32'h0);
            exp_q.push_back(word);
            fire(i, ctrl);
            wait_sig(0, 1'b1);
            for (s = 0; s < 4; s++) fire(s, ctrl);
            wait_sig(1, 1'b1);
            word = exp_q.pop_front();
            rd_chk("resh", `OFF_RESH, 32'(word[15:8]));
            rd_chk("resl", `OFF_RESL, 32'(word[7:0]));
            apb(1'b1, `OFF_RESH, 32'(~word[15:8]));
            rd_chk("resh_ro", `OFF_RESH, 32'(word[15:8]));
            rd_chk("status", `OFF_STATUS, 32'(!i[0]) << 1 | 32'h1);
            chk("irq", 32'(irq), 32'(i != 1));
            if (i == 1) apb(1'b1, `OFF_MASK, 32'h3);
            wait_sig(2, 1'b1);
            apb(1'b1, `OFF_STATUS, 32'h3);
            wait_sig(2, 1'b0);
            rd_chk("status_clr", `OFF_STATUS, 32'h0);
            chk("n_conv", 32'(n_conv), 32'(i + 1));
        end
        // Back-to-back timer triggers, then shutdown
        conv_cycles = 8'hff;
        apb(1'b1, `OFF_CTRL, 32'h3);
        timer2_ovf <= 1'b1;
        wait_sig(1, 1'b1);
        for (t = 1; t < 3000; t++) begin
            @(negedge pclk);
            if (adc_done === 1'b1) break;
        end
        chk("period", 32'(t > 376 && t < 2500), 32'h1);
        apb(1'b1, `OFF_CTRL, 32'h0);
        timer2_ovf <= 1'b0;
        repeat (2) @(negedge pclk);
        chk("abort", 32'({adc_start, adc_pwr_dn}), 32'h1);
        finish_test();
    end
endmodule : tb_adc_ctrl
